//--- logic/tcc_pkg.sv
// constants and carriers of the 8-bit timer compare block
// assumes an APB slave with 32-bit data and byte addresses
package tcc_pkg;
  // register byte addresses
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] COUNT_OFS = 8'h04;
  localparam logic [7:0] COMPARE_OFS = 8'h08;
  localparam logic [7:0] FLAGS_OFS = 8'h0C;
  localparam logic [7:0] MASK_OFS = 8'h10;
  localparam logic [7:0] PORT_OFS = 8'h14;
  // control register fields
  localparam int MODE_LSB = 0;
  localparam int ACTION_LSB = 2;
  localparam int CLKSEL_LSB = 4;
  localparam int FORCE_BIT = 7;
  // flag and mask bit positions
  localparam int OVF_BIT = 0;
  localparam int CMP_BIT = 1;
  // port register bit positions
  localparam int LATCH_BIT = 0;
  localparam int DIR_BIT = 1;
  localparam int STATE_BIT = 2;
  // counter landmarks and reset values
  localparam logic [7:0] BOTTOM = 8'h00;
  localparam logic [7:0] MAX = 8'hFF;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] COMPARE_RST = 8'h00;
  localparam logic [2:0] CLK_STOPPED = 3'h0;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_PCPWM = 2'h1,
    MODE_CLEAR_ON_MATCH = 2'h2,
    MODE_FASTPWM = 2'h3
  } tcc_mode_e;

  typedef enum logic [1:0] {
    ACT_NONE = 2'h0,
    ACT_TOGGLE = 2'h1,
    ACT_CLEAR = 2'h2,
    ACT_SET = 2'h3
  } tcc_action_e;

  typedef struct packed {
    tcc_mode_e mode;
    tcc_action_e action;
    logic [2:0] clockSel;
  } tcc_ctrl_s;

  typedef struct packed {
    logic overflow;
    logic compare;
  } tcc_flags_s;
endpackage

//--- logic/tcc_compare_timer.sv
// 8-bit timer/counter with one output compare unit and its pin override
// assumes an APB master on clk, and a prescaler tick on the same clock
`timescale 1ns/1ns
module tcc_compare_timer (
  input wire logic clk, // 20 MHz system clock
  input wire logic resetn, // asynchronous active-low reset
  input wire logic timerTickIn, // one-cycle enable from prescaler or edge detector
  input wire logic globalIrqEnable, // global interrupt enable from cpu_status_word
  input wire logic compareIrqAck, // compare interrupt being serviced
  input wire logic overflowIrqAck, // overflow interrupt being serviced
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  output logic compareIrq, // compare interrupt request
  output logic overflowIrq, // overflow interrupt request
  output logic pinOut, // pin output value
  output logic pinOen // pin output enable, low while driving
);
  logic rstMeta;
  logic rstn;
  tcc_pkg::tcc_ctrl_s ctrl;
  tcc_pkg::tcc_flags_s flags;
  tcc_pkg::tcc_flags_s mask;
  logic [7:0] countValue;
  logic [7:0] compareActive;
  logic [7:0] compareBuffer;
  logic countingDown;
  logic writeBlock;
  logic compareOutputState;
  logic portOutputLatch;
  logic pinDirection;
  logic tick;
  logic pwmMode;
  logic match;
  logic matchEvent;
  logic atTop;
  logic wrap;
  logic setupPhase;
  logic accessPhase;
  logic wrEn;
  logic addrOk;
  logic wrCtrl;
  logic wrCount;
  logic wrCompare;
  logic wrFlags;
  logic forceStrobe;
  logic next_state;
  logic [7:0] next_count;
  logic next_down;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rstMeta <= 1'b0;
      rstn <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstn <= rstMeta;
    end
  end

  // bus decode
  assign setupPhase = psel && !penable;
  assign accessPhase = psel && penable;
  assign addrOk = (paddr == tcc_pkg::CTRL_OFS) || (paddr == tcc_pkg::COUNT_OFS) ||
                  (paddr == tcc_pkg::COMPARE_OFS) || (paddr == tcc_pkg::FLAGS_OFS) ||
                  (paddr == tcc_pkg::MASK_OFS) || (paddr == tcc_pkg::PORT_OFS);
  assign pready = 1'b1;
  assign pslverr = accessPhase && !addrOk;
  assign wrEn = accessPhase && pwrite;
  assign wrCtrl = wrEn && (paddr == tcc_pkg::CTRL_OFS);
  assign wrCount = wrEn && (paddr == tcc_pkg::COUNT_OFS);
  assign wrCompare = wrEn && (paddr == tcc_pkg::COMPARE_OFS);
  assign wrFlags = wrEn && (paddr == tcc_pkg::FLAGS_OFS);
  assign forceStrobe = wrCtrl && pwdata[tcc_pkg::FORCE_BIT] && !pwmMode;

  assign tick = timerTickIn && (ctrl.clockSel != tcc_pkg::CLK_STOPPED);
  assign pwmMode = (ctrl.mode == tcc_pkg::MODE_PCPWM) || (ctrl.mode == tcc_pkg::MODE_FASTPWM);
  assign match = (countValue == compareActive);
  assign matchEvent = tick && match && !writeBlock;
  assign atTop = (countValue == tcc_pkg::MAX);

  // counting sequence, chosen by mode alone
  always_comb begin
    next_count = countValue;
    next_down = countingDown;
    case (ctrl.mode)
      tcc_pkg::MODE_NORMAL: begin
        next_count = 8'(countValue + 8'h01);
        next_down = 1'b0;
      end
      tcc_pkg::MODE_CLEAR_ON_MATCH: begin
        next_count = (match && !writeBlock) ? tcc_pkg::BOTTOM : 8'(countValue + 8'h01);
        next_down = 1'b0;
      end
      tcc_pkg::MODE_FASTPWM: begin
        next_count = atTop ? tcc_pkg::BOTTOM : 8'(countValue + 8'h01);
        next_down = 1'b0;
      end
      default: begin
        if (atTop) begin
          next_down = 1'b1;
        end else if (countValue == tcc_pkg::BOTTOM) begin
          next_down = 1'b0;
        end
        next_count = next_down ? 8'(countValue - 8'h01) : 8'(countValue + 8'h01);
      end
    endcase
  end

  assign wrap = (ctrl.mode == tcc_pkg::MODE_PCPWM) ? (countingDown && countValue == 8'h01)
                                                   : (atTop && next_count == tcc_pkg::BOTTOM);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      countValue <= tcc_pkg::COUNT_RST;
      countingDown <= 1'b0;
    end else if (wrCount) begin
      countValue <= pwdata[7:0];
    end else if (tick) begin
      countValue <= next_count;
      countingDown <= next_down;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      writeBlock <= 1'b0;
    end else if (wrCount) begin
      writeBlock <= 1'b1;
    end else if (tick) begin
      writeBlock <= 1'b0;
    end
  end

  // compare value: direct access or double buffer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      compareActive <= tcc_pkg::COMPARE_RST;
      compareBuffer <= tcc_pkg::COMPARE_RST;
    end else begin
      if (wrCompare) begin
        compareBuffer <= pwdata[7:0];
      end
      if (!pwmMode && wrCompare) begin
        compareActive <= pwdata[7:0];
      end else if (pwmMode && tick && (atTop || countValue == tcc_pkg::BOTTOM)) begin
        compareActive <= compareBuffer;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= '{tcc_pkg::MODE_NORMAL, tcc_pkg::ACT_NONE, tcc_pkg::CLK_STOPPED};
    end else if (wrCtrl) begin
      ctrl.mode <= tcc_pkg::tcc_mode_e'(pwdata[tcc_pkg::MODE_LSB +: 2]);
      ctrl.action <= tcc_pkg::tcc_action_e'(pwdata[tcc_pkg::ACTION_LSB +: 2]);
      ctrl.clockSel <= pwdata[tcc_pkg::CLKSEL_LSB +: 3];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mask <= '0;
      portOutputLatch <= 1'b0;
      pinDirection <= 1'b0;
    end else if (wrEn && paddr == tcc_pkg::MASK_OFS) begin
      mask.overflow <= pwdata[tcc_pkg::OVF_BIT];
      mask.compare <= pwdata[tcc_pkg::CMP_BIT];
    end else if (wrEn && paddr == tcc_pkg::PORT_OFS) begin
      portOutputLatch <= pwdata[tcc_pkg::LATCH_BIT];
      pinDirection <= pwdata[tcc_pkg::DIR_BIT];
    end
  end

  // flags: a setting event wins over any clear in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flags <= '0;
    end else begin
      if (matchEvent) begin
        flags.compare <= 1'b1;
      end else if (compareIrqAck || (wrFlags && pwdata[tcc_pkg::CMP_BIT])) begin
        flags.compare <= 1'b0;
      end
      if (tick && wrap && !wrCount) begin
        flags.overflow <= 1'b1;
      end else if (overflowIrqAck || (wrFlags && pwdata[tcc_pkg::OVF_BIT])) begin
        flags.overflow <= 1'b0;
      end
    end
  end

  assign compareIrq = flags.compare && mask.compare && globalIrqEnable;
  assign overflowIrq = flags.overflow && mask.overflow && globalIrqEnable;

  // waveform generator
  always_comb begin
    next_state = compareOutputState;
    if (!pwmMode) begin
      if (matchEvent || forceStrobe) begin
        case (ctrl.action)
          tcc_pkg::ACT_TOGGLE: next_state = !compareOutputState;
          tcc_pkg::ACT_CLEAR: next_state = 1'b0;
          tcc_pkg::ACT_SET: next_state = 1'b1;
          default: next_state = compareOutputState;
        endcase
      end
    end else if (ctrl.mode == tcc_pkg::MODE_FASTPWM) begin
      if (matchEvent && ctrl.action == tcc_pkg::ACT_TOGGLE) begin
        next_state = !compareOutputState;
      end else if (matchEvent && ctrl.action[1]) begin
        next_state = ctrl.action[0];
      end else if (tick && wrap && ctrl.action[1]) begin
        next_state = !ctrl.action[0];
      end
    end else if (matchEvent && ctrl.action[1]) begin
      next_state = ctrl.action[0] ^ countingDown;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      compareOutputState <= 1'b0;
    end else begin
      compareOutputState <= next_state;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pinOut <= 1'b0;
      pinOen <= 1'b1;
    end else begin
      pinOut <= (ctrl.action != tcc_pkg::ACT_NONE) ? next_state : portOutputLatch;
      pinOen <= !pinDirection;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= '0;
    end else if (setupPhase && !pwrite) begin
      if (paddr == tcc_pkg::CTRL_OFS) begin
        prdata <= {25'h0, ctrl.clockSel, ctrl.action, ctrl.mode};
      end else if (paddr == tcc_pkg::COUNT_OFS) begin
        prdata <= {24'h0, countValue};
      end else if (paddr == tcc_pkg::COMPARE_OFS) begin
        prdata <= {24'h0, pwmMode ? compareBuffer : compareActive};
      end else if (paddr == tcc_pkg::FLAGS_OFS) begin
        prdata <= {30'h0, flags.compare, flags.overflow};
      end else if (paddr == tcc_pkg::MASK_OFS) begin
        prdata <= {30'h0, mask.compare, mask.overflow};
      end else if (paddr == tcc_pkg::PORT_OFS) begin
        prdata <= {29'h0, compareOutputState, pinDirection, portOutputLatch};
      end else begin
        prdata <= '0;
      end
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  a_match_sets_flag: assert property (tick && match && !writeBlock |=> flags.compare)
    else $error("compare flag not set after match tick");
  a_blocked_no_flag: assert property (wrCount ##1 (tick && !flags.compare && !compareIrqAck) |=> !flags.compare)
    else $error("match not blocked after count write");
  a_irq_gating: assert property (compareIrq == (flags.compare && mask.compare && globalIrqEnable))
    else $error("compare interrupt gating wrong");
  a_ack_clears: assert property (compareIrqAck && !matchEvent |=> !flags.compare)
    else $error("serviced compare flag not cleared");
  a_ctc_clear: assert property (ctrl.mode == tcc_pkg::MODE_CLEAR_ON_MATCH && tick && match && !writeBlock
    && !wrCount && !wrCtrl |=> countValue == tcc_pkg::BOTTOM)
    else $error("counter not cleared on match");
  a_normal_wrap: assert property (ctrl.mode == tcc_pkg::MODE_NORMAL && tick && atTop && !wrCount
    && !wrCtrl |=> countValue == tcc_pkg::BOTTOM && flags.overflow)
    else $error("normal mode wrap or overflow wrong");
  a_stopped_hold: assert property (ctrl.clockSel == tcc_pkg::CLK_STOPPED && !wrCount |=> $stable(countValue))
    else $error("counter moved while stopped");
  a_count_write_wins: assert property (wrCount |=> countValue == $past(pwdata[7:0]))
    else $error("count write lost");
  a_force_no_flag: assert property (forceStrobe && !matchEvent && !flags.compare |=> !flags.compare)
    else $error("force strobe set compare flag");
  a_pin_source: assert property (##1 ctrl.action != tcc_pkg::ACT_NONE && $stable(ctrl.action)
    |-> pinOut == compareOutputState)
    else $error("pin not driven from output state");
  a_action_none: assert property (ctrl.action == tcc_pkg::ACT_NONE && !pwmMode |=> $stable(compareOutputState))
    else $error("output state changed with no action");

  // mode, buffer and pin checks
  a_buffer_hold: assert property (pwmMode && !(tick && (atTop || countValue == tcc_pkg::BOTTOM))
    |=> $stable(compareActive))
    else $error("buffered compare moved off top or bottom");
  a_direct_write: assert property (!pwmMode && wrCompare |=> compareActive == $past(pwdata[7:0]))
    else $error("compare write missed active register");
  a_buffer_write: assert property (wrCompare |=> compareBuffer == $past(pwdata[7:0]))
    else $error("compare write missed buffer");
  a_force_toggle: assert property (forceStrobe && ctrl.action == tcc_pkg::ACT_TOGGLE
    |=> compareOutputState != $past(compareOutputState))
    else $error("forced toggle not applied");
  a_mode_keeps_state: assert property (wrCtrl && !forceStrobe && !matchEvent && !(tick && wrap)
    |=> $stable(compareOutputState))
    else $error("output state changed on mode write");
  a_pin_enable: assert property (pinDirection |=> !pinOen)
    else $error("pin not driven with direction set");
  a_ctc_toggle: assert property (ctrl.mode == tcc_pkg::MODE_CLEAR_ON_MATCH && matchEvent
    && ctrl.action == tcc_pkg::ACT_TOGGLE |=> compareOutputState != $past(compareOutputState))
    else $error("output state not toggled on match");
  a_ctc_overflow: assert property (ctrl.mode == tcc_pkg::MODE_CLEAR_ON_MATCH && tick && atTop && !wrCount
    |=> countValue == tcc_pkg::BOTTOM && flags.overflow)
    else $error("clear-on-match wrap or overflow wrong");
  a_fast_restart: assert property (ctrl.mode == tcc_pkg::MODE_FASTPWM && tick && atTop && !wrCount
    |=> countValue == tcc_pkg::BOTTOM)
    else $error("fast pwm did not restart at bottom");
  a_dual_turn: assert property (ctrl.mode == tcc_pkg::MODE_PCPWM && tick && atTop && !wrCount
    |=> countValue == tcc_pkg::MAX - 8'h01)
    else $error("dual slope did not turn at max");
endmodule

//--- dv/test_tcc_compare_timer.sv
// self-checking bench for the 8-bit timer compare block
// assumes an APB slave that answers with pready and bench-driven one-cycle timer ticks
`timescale 1ns/1ns
module test_tcc_compare_timer;
  localparam logic [7:0] CTL = tcc_pkg::CTRL_OFS;
  localparam logic [7:0] CNT = tcc_pkg::COUNT_OFS;
  localparam logic [7:0] CMP = tcc_pkg::COMPARE_OFS;
  localparam logic [7:0] FLG = tcc_pkg::FLAGS_OFS;
  localparam logic [7:0] MSK = tcc_pkg::MASK_OFS;
  localparam logic [7:0] PRT = tcc_pkg::PORT_OFS;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic timerTickIn = 1'b0;
  logic globalIrqEnable = 1'b0;
  logic compareIrqAck = 1'b0;
  logic overflowIrqAck = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, compareIrq, overflowIrq, pinOut, pinOen;
  logic [31:0] rd;
  logic rdErr;
  int failCount = 0;
  int nChecks = 0;
  time lastApb = 0;

  always #25 clk = ~clk;

  tcc_compare_timer tcc_compare_timer_inst (
    .clk(clk), .resetn(resetn), .timerTickIn(timerTickIn), .globalIrqEnable(globalIrqEnable),
    .compareIrqAck(compareIrqAck), .overflowIrqAck(overflowIrqAck), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .compareIrq(compareIrq), .overflowIrq(overflowIrq), .pinOut(pinOut),
    .pinOen(pinOen)
  );

  task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    nChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // one APB transfer; holds the request until pready is seen at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    // a transfer that just ended in this step: let an idle edge pass first
    if (lastApb == $time) @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    lastApb = $time;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] exp, input string msg);
    apb(1'b0, a, 32'h0);
    check(rd, exp, msg);
  endtask

  task ticks(input int n);
    repeat (n) begin
      timerTickIn <= 1'b1;
      @(posedge clk);
      timerTickIn <= 1'b0;
      @(posedge clk);
    end
  endtask

  task pulse(input logic ovf);
    if (ovf) overflowIrqAck <= 1'b1; else compareIrqAck <= 1'b1;
    @(posedge clk);
    overflowIrqAck <= 1'b0;
    compareIrqAck <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic [31:0] ctl(tcc_pkg::tcc_mode_e m, tcc_pkg::tcc_action_e a, logic [2:0] c, logic f);
    return {24'h0, f, c, a, m};
  endfunction

  task t_reset;
    logic [7:0] ofs [6];
    ofs = '{CTL, CNT, CMP, FLG, MSK, PRT};
    foreach (ofs[i]) rdc(ofs[i], 32'h0, "reset value");
    check(32'(pinOut), 32'h0, "pin at reset");
    check(32'(pinOen), 32'h1, "pin enable at reset");
    apb(1'b0, 8'h18, 32'h0);
    check(32'(rdErr), 32'h1, "unmapped error");
    wr(CNT, 32'h10);
    ticks(3);
    rdc(CNT, 32'h10, "stopped count");
    $display("test reset done");
  endtask

  task t_normal;
    globalIrqEnable <= 1'b1;
    wr(MSK, 32'h1);
    wr(CMP, 32'h80);
    wr(CNT, 32'hFE);
    wr(CTL, ctl(tcc_pkg::MODE_NORMAL, tcc_pkg::ACT_NONE, 3'h1, 1'b0));
    ticks(1);
    rdc(CNT, 32'hFF, "count up");
    ticks(1);
    rdc(CNT, 32'h0, "wrap");
    rdc(FLG, 32'h1, "overflow set");
    check(32'(overflowIrq), 32'h1, "overflow irq");
    ticks(1);
    rdc(FLG, 32'h1, "overflow kept");
    pulse(1'b1);
    rdc(FLG, 32'h0, "overflow serviced");
    $display("test normal done");
  endtask

  task t_compare;
    wr(CMP, 32'h40);
    wr(CNT, 32'h40);
    ticks(1);
    rdc(FLG, 32'h0, "match blocked");
    wr(CNT, 32'h3F);
    ticks(1);
    rdc(FLG, 32'h0, "flag not yet");
    ticks(1);
    rdc(FLG, 32'h2, "flag next tick");
    wr(MSK, 32'h2);
    @(posedge clk);
    check(32'(compareIrq), 32'h1, "compare irq");
    globalIrqEnable <= 1'b0;
    @(posedge clk);
    check(32'(compareIrq), 32'h0, "irq gated");
    globalIrqEnable <= 1'b1;
    pulse(1'b0);
    rdc(FLG, 32'h0, "cleared by service");
    wr(CNT, 32'h3F);
    ticks(2);
    wr(FLG, 32'h2);
    rdc(FLG, 32'h0, "cleared by write");
    $display("test compare done");
  endtask

  task t_ctc;
    wr(PRT, 32'h2);
    wr(CMP, 32'h3);
    wr(CNT, 32'h0);
    wr(CTL, ctl(tcc_pkg::MODE_CLEAR_ON_MATCH, tcc_pkg::ACT_TOGGLE, 3'h1, 1'b0));
    check(32'(pinOen), 32'h0, "pin driven");
    ticks(4);
    check(32'(pinOut), 32'h1, "first toggle");
    rdc(CNT, 32'h0, "cleared on match");
    ticks(3);
    check(32'(pinOut), 32'h1, "half period");
    ticks(1);
    check(32'(pinOut), 32'h0, "second toggle");
    wr(CTL, ctl(tcc_pkg::MODE_CLEAR_ON_MATCH, tcc_pkg::ACT_SET, 3'h1, 1'b0));
    ticks(4);
    check(32'(pinOut), 32'h1, "new action");
    rdc(CNT, 32'h0, "same sequence");
    wr(CTL, ctl(tcc_pkg::MODE_NORMAL, tcc_pkg::ACT_SET, 3'h0, 1'b0));
    check(32'(pinOut), 32'h1, "kept on mode change");
    rdc(PRT, 32'h6, "state kept on mode change");
    wr(FLG, 32'h3);
    // the strobe applies the action already in place, so set it first
    wr(CTL, ctl(tcc_pkg::MODE_NORMAL, tcc_pkg::ACT_TOGGLE, 3'h0, 1'b0));
    wr(CTL, ctl(tcc_pkg::MODE_NORMAL, tcc_pkg::ACT_TOGGLE, 3'h0, 1'b1));
    rdc(PRT, 32'h2, "forced toggle");
    rdc(FLG, 32'h0, "force sets no flag");
    rdc(CNT, 32'h0, "force keeps count");
    wr(CTL, ctl(tcc_pkg::MODE_NORMAL, tcc_pkg::ACT_NONE, 3'h0, 1'b0));
    wr(PRT, 32'h3);
    repeat (2) @(posedge clk);
    check(32'(pinOut), 32'h1, "latch drives pin");
    $display("test clear on match done");
  endtask

  task t_miss;
    wr(CTL, ctl(tcc_pkg::MODE_CLEAR_ON_MATCH, tcc_pkg::ACT_NONE, 3'h1, 1'b0));
    wr(CNT, 32'h0A);
    wr(CMP, 32'h3);
    ticks(245);
    rdc(CNT, 32'hFF, "missed match");
    ticks(1);
    rdc(CNT, 32'h0, "wrapped");
    rdc(FLG, 32'h1, "overflow at wrap");
    ticks(4);
    rdc(CNT, 32'h0, "cleared after wrap");
    rdc(FLG, 32'h3, "match after wrap");
    rdc(PRT, 32'h3, "no action keeps state");
    $display("test missed match done");
  endtask

  task t_pwm;
    wr(FLG, 32'h3);
    wr(CTL, ctl(tcc_pkg::MODE_FASTPWM, tcc_pkg::ACT_CLEAR, 3'h1, 1'b0));
    wr(CNT, 32'h01);
    wr(CMP, 32'h05);
    rdc(CMP, 32'h05, "buffer read");
    ticks(3);
    rdc(FLG, 32'h2, "old compare still active");
    wr(CNT, 32'hFE);
    ticks(2);
    rdc(CNT, 32'h0, "fast pwm restart");
    check(32'(pinOut), 32'h1, "set at bottom");
    wr(FLG, 32'h3);
    ticks(6);
    rdc(FLG, 32'h2, "buffer loaded at top");
    check(32'(pinOut), 32'h0, "cleared on match");
    wr(CTL, ctl(tcc_pkg::MODE_PCPWM, tcc_pkg::ACT_NONE, 3'h1, 1'b0));
    wr(CNT, 32'hFE);
    ticks(3);
    rdc(CNT, 32'hFD, "dual slope turns at max");
    $display("test pwm done");
  endtask

  task summarize;
    $display("checks %0d mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_normal();
    t_compare();
    t_ctc();
    t_miss();
    t_pwm();
    summarize();
  end

  initial begin
    #(50 * 5000);
    failCount++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    summarize();
  end
endmodule
